// [hw/gpsf_pkg.sv]
package gpsf_pkg;
  // Pin and rail counts
  localparam int NIN   = 8;
  localparam int NOUT  = 4;
  localparam int NRAIL = 8;
  localparam int NSEL  = 3;

  // Register byte addresses
  localparam logic [7:0] ADDR_POL   = 8'h00;
  localparam logic [7:0] ADDR_FUNC  = 8'h04;
  localparam logic [7:0] ADDR_TERM  = 8'h10;
  localparam logic [7:0] ADDR_TEND  = 8'h2c;
  localparam logic [7:0] ADDR_STAT  = 8'h30;
  localparam logic [7:0] ADDR_CLR   = 8'h34;

  // Reset values
  localparam logic [7:0]  POL_RST  = 8'hff;
  localparam logic [15:0] FUNC_RST = 16'h0000;
  localparam logic [31:0] TERM_RST = 32'h0000_0000;

  // Status register field positions
  localparam int STAT_FAULT = 8;
  localparam int STAT_MACT  = 9;
  localparam int STAT_MLOW  = 10;
  localparam int STAT_SEL   = 11;
  localparam int STAT_OUT   = 14;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // One AND term of a logic output; sm only meaningful in term 0
  typedef struct packed {
    logic       sm;
    logic [9:0] rsvd;
    logic       use_latch;
    logic [7:0] rail;
    logic [3:0] outm;
    logic [7:0] inm;
  } gpsf_term_s;

  // One special function: enable plus the input pin it listens to
  typedef struct packed {
    logic       en;
    logic [2:0] pin;
  } gpsf_fn_s;

  typedef struct packed {
    gpsf_fn_s dir;
    gpsf_fn_s men;
    gpsf_fn_s clr;
    gpsf_fn_s flt;
  } gpsf_func_s;

  typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} gpsf_wr_e;
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} gpsf_rd_e;
endpackage

// [hw/gpsf_top.sv]
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module gpsf_top (
  // Clock, reset, enable
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      ce,
  // AXI4-Lite write
  input  wire logic [7:0]                awaddr,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  output logic [1:0]                     bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  // AXI4-Lite read
  input  wire logic [7:0]                araddr,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  // Board pins and rail flags
  input  wire logic [gpsf_pkg::NIN-1:0]   general_input_pin,
  input  wire logic [gpsf_pkg::NRAIL-1:0] rail_live,
  output logic [gpsf_pkg::NOUT-1:0]       general_output_pin,
  output logic                           margin_active,
  output logic                           margin_low,
  output logic                           margin_high,
  output logic [gpsf_pkg::NSEL-1:0]       rail_state_select,
  output logic                           fault_event
);

  // Configuration and state
  logic [gpsf_pkg::NIN-1:0]   pol;
  gpsf_pkg::gpsf_func_s       func;
  gpsf_pkg::gpsf_term_s       term [2*gpsf_pkg::NOUT];
  logic [gpsf_pkg::NIN-1:0]   act;
  logic [gpsf_pkg::NIN-1:0]   act_q;
  logic [gpsf_pkg::NRAIL-1:0] latched;
  logic                       fault_sticky;
  gpsf_pkg::gpsf_wr_e         wr_st;
  gpsf_pkg::gpsf_rd_e         rd_st;
  logic                       aw_got;
  logic                       w_got;
  logic [7:0]                 aw_addr;
  logic [31:0]                w_data;
  logic [3:0]                 w_strb;
  logic [gpsf_pkg::NOUT-1:0]  t0_hit;
  logic [gpsf_pkg::NOUT-1:0]  t1_hit;
  logic [gpsf_pkg::NOUT-1:0]  next_out;
  logic                       fault_fall;
  logic                       clr_act;
  logic                       men_act;
  logic                       dir_act;
  logic                       do_write;
  logic                       func_conflict;
  logic [15:0]                next_func;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // A term with no masks set is FALSE so an unused path never fires
  function automatic logic term_true(input gpsf_pkg::gpsf_term_s t,
                                     input logic [7:0] ins,
                                     input logic [3:0] outs,
                                     input logic [7:0] rails);
    logic any;
    any = |{t.inm, t.outm, t.rail};
    return any && ((ins & t.inm) == t.inm) &&
           ((outs & t.outm) == t.outm) && ((rails & t.rail) == t.rail);
  endfunction

  // Selected pin of a special function, already polarity-corrected
  function automatic logic fn_level(input gpsf_pkg::gpsf_fn_s f,
                                    input logic [7:0] a);
    return f.en && a[f.pin];
  endfunction

  // Function field check: an owned function refuses another pin
  function automatic logic fn_clash(input logic [3:0] cur,
                                    input logic [3:0] nw);
    return cur[3] && nw[3] && (cur[2:0] != nw[2:0]);
  endfunction

  assign act = ~(general_input_pin ^ pol);

  // Special function levels, all from corrected inputs
  assign clr_act    = fn_level(func.clr, act_q);
  assign men_act    = fn_level(func.men, act_q);
  assign dir_act    = fn_level(func.dir, act_q);
  assign fault_fall = func.flt.en && act_q[func.flt.pin] &&
                      !act[func.flt.pin];

  // AND term evaluation per output; rails live or sticky per term
  always_comb begin
    for (int i = 0; i < gpsf_pkg::NOUT; i++) begin
      t0_hit[i] = term_true(term[2*i], act_q, general_output_pin,
                            term[2*i].use_latch ? latched : rail_live);
      t1_hit[i] = term_true(term[2*i+1], act_q, general_output_pin,
                            term[2*i+1].use_latch ? latched : rail_live);
      if (term[2*i].sm) begin
        // Only the path matching the present result is looked at
        next_out[i] = general_output_pin[i] ? t0_hit[i]
                                            : t1_hit[i];
      end else begin
        next_out[i] = t0_hit[i] | t1_hit[i];
      end
    end
  end

  // Input sampling; registered to give a clean edge for fault detect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_q <= 8'h00;
    end else if (ce) begin
      act_q <= act;
    end
  end

  // Logic outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      general_output_pin <= 4'h0;
    end else if (ce) begin
      general_output_pin <= next_out;
    end
  end

  // Margin and selector outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      margin_active     <= 1'b0;
      margin_low        <= 1'b0;
      margin_high       <= 1'b0;
      rail_state_select <= 3'h0;
    end else if (ce) begin
      margin_active     <= men_act;
      margin_low        <= men_act && dir_act;
      margin_high       <= men_act && !dir_act;
      rail_state_select <= act[gpsf_pkg::NSEL-1:0];
    end
  end

  // Fault event pulse and its sticky flag; a new fault beats a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_event  <= 1'b0;
      fault_sticky <= 1'b0;
    end else if (ce) begin
      fault_event <= fault_fall;
      if (fault_fall) begin
        fault_sticky <= 1'b1;
      end else if (do_write && aw_addr == gpsf_pkg::ADDR_CLR &&
                   w_strb[1] && w_data[gpsf_pkg::STAT_FAULT]) begin
        fault_sticky <= 1'b0;
      end
    end
  end

  // Sticky rail statuses; a live flag wins over either clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latched <= 8'h00;
    end else if (ce) begin
      if (clr_act) begin
        latched <= rail_live;
      end else if (do_write && aw_addr == gpsf_pkg::ADDR_CLR &&
                   w_strb[0]) begin
        latched <= (latched & ~w_data[7:0]) | rail_live;
      end else begin
        latched <= latched | rail_live;
      end
    end
  end

  // Write channel: address and data taken in either order
  assign do_write = (wr_st == gpsf_pkg::WR_IDLE) && aw_got && w_got;
  assign next_func = 16'(merge({16'h0000, func}, w_data, w_strb));
  assign func_conflict = fn_clash(func[15:12], next_func[15:12]) ||
                         fn_clash(func[11:8], next_func[11:8]) ||
                         fn_clash(func[7:4], next_func[7:4]) ||
                         fn_clash(func[3:0], next_func[3:0]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_st   <= gpsf_pkg::WR_IDLE;
      awready <= 1'b0;
      wready  <= 1'b0;
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= gpsf_pkg::RESP_OKAY;
    end else if (ce) begin
      case (wr_st)
        gpsf_pkg::WR_IDLE: begin
          awready <= !aw_got && !(awvalid && awready);
          wready  <= !w_got && !(wvalid && wready);
          if (awvalid && awready) begin
            aw_got  <= 1'b1;
            aw_addr <= awaddr;
          end
          if (wvalid && wready) begin
            w_got  <= 1'b1;
            w_data <= wdata;
            w_strb <= wstrb;
          end
          if (do_write) begin
            wr_st  <= gpsf_pkg::WR_RESP;
            bvalid <= 1'b1;
            if (aw_addr == gpsf_pkg::ADDR_POL ||
                aw_addr == gpsf_pkg::ADDR_CLR ||
                (aw_addr == gpsf_pkg::ADDR_FUNC && !func_conflict) ||
                (aw_addr >= gpsf_pkg::ADDR_TERM &&
                 aw_addr <= gpsf_pkg::ADDR_TEND && aw_addr[1:0] == 2'b00))
            begin
              bresp <= gpsf_pkg::RESP_OKAY;
            end else begin
              bresp <= gpsf_pkg::RESP_SLVERR;
            end
          end
        end
        gpsf_pkg::WR_RESP: begin
          if (bready) begin
            bvalid <= 1'b0;
            aw_got <= 1'b0;
            w_got  <= 1'b0;
            wr_st  <= gpsf_pkg::WR_IDLE;
          end
        end
        default: begin
          wr_st <= gpsf_pkg::WR_IDLE;
        end
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pol  <= gpsf_pkg::POL_RST;
      func <= gpsf_pkg::FUNC_RST;
      for (int k = 0; k < 2*gpsf_pkg::NOUT; k++) begin
        term[k] <= gpsf_pkg::TERM_RST;
      end
    end else if (ce && do_write) begin
      if (aw_addr == gpsf_pkg::ADDR_POL) begin
        pol <= 8'(merge({24'h00_0000, pol}, w_data, w_strb));
      end
      // A clash refuses the whole write so no function moves pins
      if (aw_addr == gpsf_pkg::ADDR_FUNC && !func_conflict) begin
        func <= next_func;
      end
      for (int k = 0; k < 2*gpsf_pkg::NOUT; k++) begin
        if (aw_addr == gpsf_pkg::ADDR_TERM + 8'(4*k)) begin
          term[k] <= merge(term[k], w_data, w_strb);
        end
      end
    end
  end

  // Read channel; data is captured with the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_st   <= gpsf_pkg::RD_IDLE;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= gpsf_pkg::RESP_OKAY;
    end else if (ce) begin
      case (rd_st)
        gpsf_pkg::RD_IDLE: begin
          arready <= !(arvalid && arready);
          if (arvalid && arready) begin
            rd_st  <= gpsf_pkg::RD_DATA;
            rvalid <= 1'b1;
            rresp  <= gpsf_pkg::RESP_OKAY;
            rdata  <= 32'h0000_0000;
            if (araddr == gpsf_pkg::ADDR_POL) begin
              rdata[7:0] <= pol;
            end else if (araddr == gpsf_pkg::ADDR_FUNC) begin
              rdata[15:0] <= func;
            end else if (araddr == gpsf_pkg::ADDR_STAT) begin
              rdata[7:0] <= latched;
              rdata[gpsf_pkg::STAT_FAULT] <= fault_sticky;
              rdata[gpsf_pkg::STAT_MACT]  <= margin_active;
              rdata[gpsf_pkg::STAT_MLOW]  <= margin_low;
              rdata[gpsf_pkg::STAT_SEL +: 3] <= rail_state_select;
              rdata[gpsf_pkg::STAT_OUT +: 4] <= general_output_pin;
            end else if (araddr >= gpsf_pkg::ADDR_TERM &&
                         araddr <= gpsf_pkg::ADDR_TEND &&
                         araddr[1:0] == 2'b00) begin
              rdata <= term[3'(araddr[4:2] - 3'h4)];
            end else if (araddr != gpsf_pkg::ADDR_CLR) begin
              rresp <= gpsf_pkg::RESP_SLVERR;
            end
          end
        end
        gpsf_pkg::RD_DATA: begin
          if (rready) begin
            rvalid <= 1'b0;
            rd_st  <= gpsf_pkg::RD_IDLE;
          end
        end
        default: begin
          rd_st <= gpsf_pkg::RD_IDLE;
        end
      endcase
    end
  end

  // Checks on the logic above
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Output 1 is the one the bench runs in state-machine mode
  AST_PATH0: assert property (ce && term[2].sm &&
    general_output_pin[1] |=> general_output_pin[1] == $past(t0_hit[1]))
    else $error("path 0 not used while result true");
  AST_PATH1: assert property (ce && term[2].sm &&
    !general_output_pin[1] |=> general_output_pin[1] == $past(t1_hit[1]))
    else $error("path 1 not used while result false");
  AST_ONE_PATH: assert property (ce && term[2].sm && !t1_hit[1] &&
    !general_output_pin[1] && t0_hit[1] |=> !general_output_pin[1])
    else $error("both paths evaluated in state-machine mode");
  AST_OR_TERMS: assert property (ce && !term[0].sm
    |=> general_output_pin[0] == $past(t0_hit[0] | t1_hit[0]))
    else $error("output is not OR of terms");
  AST_FAULT: assert property (ce && fault_fall
    |=> fault_event && fault_sticky)
    else $error("fault not raised on de-assertion");
  AST_CLEAR: assert property (ce && clr_act && rail_live == 8'h00
    |=> latched == 8'h00)
    else $error("clear source did not clear statuses");
  AST_STICKY: assert property (ce && !clr_act &&
    !(do_write && aw_addr == gpsf_pkg::ADDR_CLR)
    |=> (latched & $past(latched)) == $past(latched))
    else $error("sticky status dropped without clear");
  AST_MARGIN_EN: assert property (ce && men_act
    |=> margin_active && (margin_low ^ margin_high))
    else $error("margin not entered");
  AST_MARGIN_LOW: assert property (ce && men_act && dir_act
    |=> margin_low && !margin_high)
    else $error("low margin not selected");
  AST_MARGIN_HIGH: assert property (ce && men_act && !dir_act
    |=> margin_high && !margin_low)
    else $error("high margin not selected");
  AST_POLARITY: assert property (ce
    |=> act_q == ~($past(general_input_pin) ^ $past(pol)))
    else $error("polarity not applied");
  AST_SELECT: assert property (ce |=> rail_state_select ==
    ~($past(general_input_pin[2:0]) ^ $past(pol[2:0])))
    else $error("selector not from first inputs");
  AST_REFUSE: assert property (ce && do_write &&
    aw_addr == gpsf_pkg::ADDR_FUNC && func_conflict
    |=> bresp == gpsf_pkg::RESP_SLVERR && func == $past(func))
    else $error("second pin for a function accepted");

  COV_SM: cover property (term[2].sm && general_output_pin[1]
    ##1 !general_output_pin[1]);
  COV_FAULT: cover property (fault_event);
  COV_MLOW: cover property (margin_high ##[1:20] margin_low);
  COV_REFUSE: cover property (do_write && func_conflict);

endmodule

// [verif/gpsf_board.sv]
`timescale 1ns/1ps
// Board-side logic that drives the input pins and rail flags
module gpsf_board (
  // Clock
  input  wire logic       aclk,
  // Levels the bench asks for
  input  wire logic [7:0] pin_req,
  input  wire logic [7:0] rail_req,
  // Lines into the block
  output logic      [7:0] general_input_pin,
  output logic      [7:0] rail_live
);
  // Launched on the clock so levels never change at the sampling point
  always_ff @(posedge aclk) begin
    general_input_pin <= pin_req;
    rail_live         <= rail_req;
  end
endmodule

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  // Clock, reset and bus signals
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic        ce      = 1'b1;
  logic [7:0]  awaddr  = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata   = 32'h0000_0000;
  logic [3:0]  wstrb   = 4'h0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic [7:0]  araddr  = 8'h00;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  pin_req  = 8'h00;
  logic [7:0]  rail_req = 8'h00;
  logic [7:0]  gpin, rlive;
  logic [3:0]  gout;
  logic [2:0]  rsel;
  logic        m_act, m_low, m_high, fault_event;
  int          errors = 0;
  int          checks = 0;
  int          fcnt   = 0;
  logic [31:0] d;
  logic [1:0]  r;

  always #5 aclk = ~aclk;

  gpsf_board BOARD (.aclk(aclk), .pin_req(pin_req), .rail_req(rail_req),
    .general_input_pin(gpin), .rail_live(rlive));

  gpsf_top DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .general_input_pin(gpin), .rail_live(rlive),
    .general_output_pin(gout), .margin_active(m_act), .margin_low(m_low),
    .margin_high(m_high), .rail_state_select(rsel),
    .fault_event(fault_event));

  // Fault pulses last one cycle, so count them on every edge
  always @(posedge aclk) begin
    if (fault_event === 1'b1) fcnt++;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Packed as {active, low, high, select[2:0], outputs[3:0]}
  task automatic chk_out(input logic [9:0] exp);
    checks++;
    if ({m_act, m_low, m_high, rsel, gout} !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time,
               {m_act, m_low, m_high, rsel, gout}, exp);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                        output logic [1:0] resp);
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= v;
    wstrb   <= 4'hf;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (1) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
                        output logic [1:0] resp);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (1) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic wr_ok(input logic [7:0] a, input logic [31:0] v);
    axi_wr(a, v, r);
    chk_resp(r, gpsf_pkg::RESP_OKAY);
  endtask

  task automatic rd_cmp(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    axi_rd(a, d, r);
    chk_resp(r, gpsf_pkg::RESP_OKAY);
    chk_word(d & m, exp);
  endtask

  // Board path, input register and output register all need to settle
  task automatic pins(input logic [7:0] p, input logic [7:0] rl);
    pin_req  <= p;
    rail_req <= rl;
    repeat (5) @(posedge aclk);
  endtask

  // Output and state-machine steps: pin levels and expected outputs
  logic [7:0] sm_pin [5] = '{8'h01, 8'h03, 8'h01, 8'h00, 8'h01};
  logic [9:0] sm_exp [5] = '{10'h011, 10'h033, 10'h013, 10'h000, 10'h011};
  // Margin steps: enable only, enable with low, direction only
  logic [7:0] mg_pin [3] = '{8'h40, 8'hc0, 8'h80};
  logic [9:0] mg_exp [3] = '{10'h280, 10'h300, 10'h000};

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd_cmp(gpsf_pkg::ADDR_POL, 32'hffff_ffff, 32'h0000_00ff);
    rd_cmp(gpsf_pkg::ADDR_FUNC, 32'hffff_ffff, 32'h0000_0000);
    rd_cmp(gpsf_pkg::ADDR_TERM, 32'hffff_ffff, 32'h0000_0000);
    axi_rd(8'h40, d, r);
    chk_resp(r, gpsf_pkg::RESP_SLVERR);
    chk_word(d, 32'h0000_0000);
    axi_wr(8'h02, 32'h0000_0000, r);
    chk_resp(r, gpsf_pkg::RESP_SLVERR);
    // Output 0: OR of an input-0 term and an input-1 term
    wr_ok(8'h10, 32'h0000_0001);
    wr_ok(8'h14, 32'h0000_0002);
    pins(8'h02, 8'h00);
    chk_out(10'h021);
    pins(8'h00, 8'h00);
    chk_out(10'h000);
    // Input 0 flipped to active low: low pin now reads asserted
    wr_ok(gpsf_pkg::ADDR_POL, 32'h0000_00fe);
    pins(8'h00, 8'h00);
    chk_out(10'h011);
    wr_ok(gpsf_pkg::ADDR_POL, 32'h0000_00ff);
    // Output 1 in state-machine mode: path 0 on input 0, path 1 on input 1
    wr_ok(8'h18, 32'h8000_0001);
    wr_ok(8'h1c, 32'h0000_0002);
    for (int i = 0; i < 5; i++) begin
      pins(sm_pin[i], 8'h00);
      chk_out(sm_exp[i]);
    end
    // Fault on pin 3, clear on pin 5, margin enable 6, direction 7
    wr_ok(gpsf_pkg::ADDR_FUNC, 32'h0000_fedb);
    axi_wr(gpsf_pkg::ADDR_FUNC, 32'h0000_fedc, r);
    chk_resp(r, gpsf_pkg::RESP_SLVERR);
    rd_cmp(gpsf_pkg::ADDR_FUNC, 32'h0000_ffff, 32'h0000_fedb);
    pins(8'h08, 8'h01);
    pins(8'h00, 8'h00);
    chk_word(fcnt, 32'd1);
    rd_cmp(gpsf_pkg::ADDR_STAT, 32'h0000_01ff, 32'h0000_0101);
    wr_ok(gpsf_pkg::ADDR_CLR, 32'h0000_0100);
    rd_cmp(gpsf_pkg::ADDR_STAT, 32'h0000_01ff, 32'h0000_0001);
    pins(8'h20, 8'h00);
    pins(8'h00, 8'h00);
    rd_cmp(gpsf_pkg::ADDR_STAT, 32'h0000_00ff, 32'h0000_0000);
    // Rail 1 latched by a short live pulse, then cleared over the bus
    pins(8'h00, 8'h02);
    pins(8'h00, 8'h00);
    rd_cmp(gpsf_pkg::ADDR_STAT, 32'h0000_00ff, 32'h0000_0002);
    wr_ok(gpsf_pkg::ADDR_CLR, 32'h0000_0002);
    rd_cmp(gpsf_pkg::ADDR_STAT, 32'h0000_00ff, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      pins(mg_pin[i], 8'h00);
      chk_out(mg_exp[i]);
    end
    print_verdict();
  end

  // Whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    print_verdict();
  end
endmodule
